// File: src/mio_top.v
// Motion I/O: general outputs, TTL inputs, position compare, amplifier
// enable, error output and analog readback, with an AXI4-Lite slave.
// Assumes encoder positions, errors and ADC codes arrive synchronous.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "mio_defs.vh"

module mio_top #(
    parameter NAXES    = 8,
    parameter ADC_BITS = 12,
    parameter PW       = 32
) (
    // Clock and reset
    input  wire                I_CORE_CLK,
    input  wire                I_ARST_N,
    // Field and axis side
    input  wire                I_LOCAL_RESET_N,
    input  wire                I_PROC_SELF_RESET,
    input  wire [NAXES*PW-1:0] I_ENC_POS,
    input  wire [NAXES*PW-1:0] I_POS_ERR,
    input  wire [7:0]          I_TTL_IN,
    input  wire [8*16-1:0]     I_ANALOG_IN,
    output reg                 O_AMP_ENABLE_OUT,
    output reg                 O_COMPARE_OUT_N,
    output reg                 O_ERROR_N,
    output reg                 O_ERROR_LED,
    output reg                 O_CTRL_RESET,
    output reg  [15:0]         O_GP_OUT,
    // AXI4-Lite write
    input  wire [5:0]          I_AWADDR,
    input  wire                I_AWVALID,
    output reg                 O_AWREADY,
    input  wire [31:0]         I_WDATA,
    input  wire [3:0]          I_WSTRB,
    input  wire                I_WVALID,
    output reg                 O_WREADY,
    output reg  [1:0]          O_BRESP,
    output reg                 O_BVALID,
    input  wire                I_BREADY,
    // AXI4-Lite read
    input  wire [5:0]          I_ARADDR,
    input  wire                I_ARVALID,
    output reg                 O_ARREADY,
    output reg  [31:0]         O_RDATA,
    output reg  [1:0]          O_RRESP,
    output reg                 O_RVALID,
    input  wire                I_RREADY
);
    localparam PULSE_CYC = (`MIO_CMP_PULSE_NS + `MIO_CLK_PERIOD_NS - 1)
                           / `MIO_CLK_PERIOD_NS;
    localparam [15:0] OUT_MASK = (NAXES >= 5) ? 16'hFFFF : 16'h00FF;

    // Register state
    reg [2:0]  ctrl_ff;
    reg [15:0] out_ff;
    reg [PW-1:0] limit_ff;
    reg [5:0]  cmp_cfg_ff;
    reg [PW-1:0] cmp_val_ff;
    reg [2:0]  an_idx_ff;
    reg        cmp_fired_ff;

    // Write channel capture
    reg [5:0]  aw_addr_ff;
    reg        aw_have_ff;
    reg [31:0] w_data_ff;
    reg [3:0]  w_strb_ff;
    reg        w_have_ff;

    // Local reset: controller-only soft reset, host bus untouched
    wire soft_rst = ~I_LOCAL_RESET_N;

    // Excess position error per axis
    wire [NAXES-1:0] excess;
    genvar g;
    generate
        for (g = 0; g < NAXES; g = g + 1) begin : g_axis
            mio_axis_err #(.W(PW)) u_err (
                .i_clk    (I_CORE_CLK),
                .i_arst_n (I_ARST_N),
                .i_pos_err(I_POS_ERR[g*PW +: PW]),
                .i_limit  (limit_ff),
                .o_excess (excess[g])
            );
        end
    endgenerate
    wire any_excess = |excess;

    // Error conditions
    wire err_now = any_excess | soft_rst | I_PROC_SELF_RESET;

    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_ERROR_N   <= 1'b1;
            O_ERROR_LED <= 1'b0;
        end else begin
            O_ERROR_N   <= ~err_now;
            O_ERROR_LED <= err_now;
        end
    end

    // Amplifier enable
    wire amp_off = ctrl_ff[`MIO_CTRL_WDOG_FIRE] |
                   ctrl_ff[`MIO_CTRL_MOTOR_OFF] |
                   (ctrl_ff[`MIO_CTRL_OFF_ON_ERR] & any_excess);

    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_AMP_ENABLE_OUT <= 1'b0;
            O_CTRL_RESET     <= 1'b0;
        end else begin
            O_AMP_ENABLE_OUT <= ~amp_off & ~soft_rst;
            O_CTRL_RESET     <= soft_rst;
        end
    end

    // Position compare
    wire [2:0]    cmp_axis = cmp_cfg_ff[`MIO_CMP_AXIS_LSB +: 3];
    wire          cmp_mode = cmp_cfg_ff[`MIO_CMP_MODE_BIT];
    wire          cmp_arm  = cmp_cfg_ff[`MIO_CMP_ARM_BIT];
    wire [PW-1:0] cmp_pos  = I_ENC_POS[cmp_axis*PW +: PW];
    reg  [PW-1:0] next_hit_ff;
    reg  [PW-1:0] prev_pos_ff;
    reg  [9:0]    pulse_cnt_ff;
    reg           cfg_wr_pulse;

    wire interval_hit = ~cmp_mode && cmp_arm && (cmp_val_ff != {PW{1'b0}})
                        && ($signed(cmp_pos) >= $signed(next_hit_ff));
    wire passed = ($signed(prev_pos_ff) < $signed(cmp_val_ff)) !=
                  ($signed(cmp_pos) < $signed(cmp_val_ff));
    wire setpoint_hit = cmp_mode && cmp_arm && !cmp_fired_ff && passed;

    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            next_hit_ff     <= {PW{1'b0}};
            prev_pos_ff     <= {PW{1'b0}};
            pulse_cnt_ff    <= 10'h000;
            cmp_fired_ff    <= 1'b0;
            O_COMPARE_OUT_N <= 1'b1;
        // A new setup outranks a hit judged against the old one
        end else if (soft_rst || cfg_wr_pulse) begin
            next_hit_ff     <= cmp_pos + cmp_val_ff;
            prev_pos_ff     <= cmp_pos;
            pulse_cnt_ff    <= 10'h000;
            cmp_fired_ff    <= 1'b0;
            O_COMPARE_OUT_N <= 1'b1;
        end else begin
            prev_pos_ff <= cmp_pos;
            if (interval_hit) begin
                // Interval mode: 1 us active-low pulse per step
                next_hit_ff     <= next_hit_ff + cmp_val_ff;
                pulse_cnt_ff    <= PULSE_CYC[9:0];
                O_COMPARE_OUT_N <= 1'b0;
            end else if (pulse_cnt_ff != 10'h000) begin
                pulse_cnt_ff    <= pulse_cnt_ff - 10'h001;
                O_COMPARE_OUT_N <= (pulse_cnt_ff == 10'h001);
            end
            if (setpoint_hit) begin
                // Set-point mode: latch low once until re-armed
                cmp_fired_ff    <= 1'b1;
                O_COMPARE_OUT_N <= 1'b0;
            end
        end
    end

    // AXI4-Lite write path
    wire do_write = aw_have_ff && w_have_ff && !O_BVALID;
    wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                         {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wire [3:0] bit_idx = w_data_ff[`MIO_OBIT_IDX_LSB +: 4];
    wire [1:0] bit_op  = w_data_ff[`MIO_OBIT_OP_LSB +: 2];
    // Analog index is the one writable word above the compare block
    wire       wr_ok   = ((aw_addr_ff <= `MIO_OFS_CMP_VALUE) ||
                          (aw_addr_ff == `MIO_OFS_ANALOG_IX)) &&
                         (aw_addr_ff[1:0] == 2'h0);

    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            aw_addr_ff <= 6'h00;
            aw_have_ff <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            w_have_ff  <= 1'b0;
            O_AWREADY  <= 1'b0;
            O_WREADY   <= 1'b0;
            O_BVALID   <= 1'b0;
            O_BRESP    <= `MIO_RESP_OKAY;
        end else begin
            O_AWREADY <= !aw_have_ff && !(I_AWVALID && O_AWREADY);
            O_WREADY  <= !w_have_ff && !(I_WVALID && O_WREADY);
            if (I_AWVALID && O_AWREADY) begin
                aw_addr_ff <= I_AWADDR;
                aw_have_ff <= 1'b1;
            end
            if (I_WVALID && O_WREADY) begin
                w_data_ff <= I_WDATA;
                w_strb_ff <= I_WSTRB;
                w_have_ff <= 1'b1;
            end
            if (do_write) begin
                aw_have_ff <= 1'b0;
                w_have_ff  <= 1'b0;
                O_BVALID   <= 1'b1;
                O_BRESP    <= wr_ok ? `MIO_RESP_OKAY : `MIO_RESP_SLVERR;
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end

    // Register updates; soft reset restores controller state
    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_ff      <= 3'h0;
            out_ff       <= `MIO_RST_OUT_PORT;
            limit_ff     <= `MIO_RST_ERR_LIMIT;
            cmp_cfg_ff   <= 6'h00;
            cmp_val_ff   <= {PW{1'b0}};
            an_idx_ff    <= 3'h0;
            cfg_wr_pulse <= 1'b0;
        end else if (soft_rst) begin
            ctrl_ff      <= 3'h0;
            out_ff       <= `MIO_RST_OUT_PORT;
            cmp_cfg_ff   <= 6'h00;
            cfg_wr_pulse <= 1'b0;
        end else begin
            cfg_wr_pulse <= 1'b0;
            if (do_write) begin
                case (aw_addr_ff)
                    `MIO_OFS_CTRL: begin
                        ctrl_ff <= (ctrl_ff & ~wmask[2:0]) |
                                   (w_data_ff[2:0] & wmask[2:0]);
                    end
                    `MIO_OFS_OUT_PORT: begin
                        out_ff <= ((out_ff & ~wmask[15:0]) |
                                  (w_data_ff[15:0] & wmask[15:0]))
                                  & OUT_MASK;
                    end
                    `MIO_OFS_OUT_BIT: begin
                        case (bit_op)
                            `MIO_OBIT_SET:
                                out_ff <= (out_ff | (16'h0001 << bit_idx))
                                          & OUT_MASK;
                            `MIO_OBIT_CLEAR:
                                out_ff <= out_ff & ~(16'h0001 << bit_idx);
                            `MIO_OBIT_WRITE: begin
                                out_ff <= ((out_ff & ~(16'h0001 << bit_idx))
                                    | ({15'h0000, w_data_ff[`MIO_OBIT_VAL]}
                                    << bit_idx)) & OUT_MASK;
                            end
                            default: out_ff <= out_ff;
                        endcase
                    end
                    `MIO_OFS_ERR_LIMIT: begin
                        limit_ff <= (limit_ff & ~wmask[PW-1:0]) |
                                    (w_data_ff[PW-1:0] & wmask[PW-1:0]);
                    end
                    `MIO_OFS_CMP_CFG: begin
                        cmp_cfg_ff   <= w_data_ff[5:0];
                        cfg_wr_pulse <= 1'b1;
                    end
                    `MIO_OFS_CMP_VALUE: begin
                        cmp_val_ff   <= w_data_ff[PW-1:0];
                        cfg_wr_pulse <= 1'b1;
                    end
                    `MIO_OFS_ANALOG_IX: begin
                        an_idx_ff <= w_data_ff[2:0];
                    end
                    default: ctrl_ff <= ctrl_ff;
                endcase
            end
        end
    end

    // General outputs straight from the port register
    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_GP_OUT <= `MIO_RST_OUT_PORT;
        end else begin
            O_GP_OUT <= out_ff;
        end
    end

    // Analog code: 12-bit converter uses the low bits of each lane
    wire [15:0] an_lane = I_ANALOG_IN[an_idx_ff*16 +: 16];
    wire [15:0] an_code = (ADC_BITS >= 16) ? an_lane
                          : (an_lane & ((16'h0001 << ADC_BITS) - 16'h0001));

    // Read mux
    reg [31:0] rd_word;
    reg        rd_ok;
    always @* begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        case (I_ARADDR)
            `MIO_OFS_CTRL:      rd_word = {29'h0, ctrl_ff};
            `MIO_OFS_OUT_PORT:  rd_word = {16'h0000, out_ff};
            `MIO_OFS_OUT_BIT:   rd_word = 32'h0000_0000;  // Write-only
            `MIO_OFS_ERR_LIMIT: rd_word = limit_ff;
            `MIO_OFS_CMP_CFG:   rd_word = {26'h0, cmp_cfg_ff};
            `MIO_OFS_CMP_VALUE: rd_word = cmp_val_ff;
            `MIO_OFS_STATUS:    rd_word = {16'h0000, excess[7:0] & 8'hFF,
                                    3'h0, O_AMP_ENABLE_OUT, !O_ERROR_N,
                                    cmp_fired_ff, !O_COMPARE_OUT_N,
                                    soft_rst};
            `MIO_OFS_TTL_IN:    rd_word = (NAXES >= 5) ?
                                    {24'h0, I_TTL_IN} : 32'h0;
            `MIO_OFS_ANALOG_IX: rd_word = {29'h0, an_idx_ff};
            `MIO_OFS_ANALOG_RD: rd_word = {16'h0000, an_code};
            default:            rd_ok = 1'b0;
        endcase
    end

    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h0000_0000;
            O_RRESP   <= `MIO_RESP_OKAY;
        end else begin
            O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA  <= rd_word;
                O_RRESP  <= rd_ok ? `MIO_RESP_OKAY : `MIO_RESP_SLVERR;
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end
endmodule // mio_top

// File: src/mio_defs.vh
// Constants for the motion I/O, enable and error logic.
// Assumes inclusion by bare name from the design files under src/.
`ifndef MIO_DEFS_VH
`define MIO_DEFS_VH

// Register byte offsets on the AXI4-Lite slave
`define MIO_OFS_CTRL      6'h00
`define MIO_OFS_OUT_PORT  6'h04
`define MIO_OFS_OUT_BIT   6'h08
`define MIO_OFS_ERR_LIMIT 6'h0C
`define MIO_OFS_CMP_CFG   6'h10
`define MIO_OFS_CMP_VALUE 6'h14
`define MIO_OFS_STATUS    6'h18
`define MIO_OFS_TTL_IN    6'h1C
`define MIO_OFS_ANALOG_IX 6'h20
`define MIO_OFS_ANALOG_RD 6'h24

// Control register fields
`define MIO_CTRL_MOTOR_OFF 0
`define MIO_CTRL_OFF_ON_ERR 1
`define MIO_CTRL_WDOG_FIRE 2

// Output bit command fields
`define MIO_OBIT_IDX_LSB  0
`define MIO_OBIT_OP_LSB   8
`define MIO_OBIT_SET      2'h1
`define MIO_OBIT_CLEAR    2'h2
`define MIO_OBIT_WRITE    2'h3
`define MIO_OBIT_VAL      16

// Compare config fields
`define MIO_CMP_AXIS_LSB  0
`define MIO_CMP_MODE_BIT  4
`define MIO_CMP_ARM_BIT   5

// Reset values
`define MIO_RST_OUT_PORT  16'h0000
`define MIO_RST_ERR_LIMIT 32'h0000_0400

// Compare pulse width
`define MIO_CMP_PULSE_NS  1000
`define MIO_CLK_PERIOD_NS 4

// Bus answers
`define MIO_RESP_OKAY     2'h0
`define MIO_RESP_SLVERR   2'h2

`endif

// File: src/mio_axis_err.v
// Per-axis excess-error detector: |position error| against a limit.
// Assumes the error sample is signed and synchronous to the core clock.
`timescale 1ns/1ns
module mio_axis_err #(
    parameter W = 32
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_arst_n,
    // Data
    input  wire [W-1:0] i_pos_err,
    input  wire [W-1:0] i_limit,
    output reg          o_excess
);
    wire [W-1:0] mag = i_pos_err[W-1] ? (~i_pos_err + {{(W-1){1'b0}}, 1'b1})
                                      : i_pos_err;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_excess <= 1'b0;
        end else begin
            o_excess <= (mag > i_limit);
        end
    end
endmodule // mio_axis_err

// File: verif/mio_chk_assertions.sv
// Checker for the motion I/O top: error, enable, compare, bus answers.
// Assumes it is bound to mio_top and sees that module's ports only.
`timescale 1ns/1ns
module mio_chk (
    // Clock and reset
    input wire I_CORE_CLK,
    input wire I_ARST_N,
    // Watched inputs
    input wire I_LOCAL_RESET_N,
    input wire I_PROC_SELF_RESET,
    input wire I_ARVALID,
    input wire I_BREADY,
    // Watched outputs
    input wire O_ARREADY,
    input wire O_RVALID,
    input wire O_BVALID,
    input wire O_AMP_ENABLE_OUT,
    input wire O_COMPARE_OUT_N,
    input wire O_ERROR_N,
    input wire O_ERROR_LED,
    input wire O_CTRL_RESET
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_ARST_N);

    a_led_err_match: assert property (
        O_ERROR_LED == !O_ERROR_N)
        else $error("error lamp disagrees with error output");
    a_local_rst_err: assert property (
        !I_LOCAL_RESET_N |=> !O_ERROR_N)
        else $error("local reset did not pull error output low");
    a_self_rst_err: assert property (
        I_PROC_SELF_RESET |=> !O_ERROR_N)
        else $error("self reset did not pull error output low");
    a_amp_local_off: assert property (
        !I_LOCAL_RESET_N |=> !O_AMP_ENABLE_OUT)
        else $error("amplifier stayed enabled in local reset");
    a_ctrl_rst_flag: assert property (
        !I_LOCAL_RESET_N |=> O_CTRL_RESET)
        else $error("controller reset flag missing");
    a_read_answer: assert property (
        I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read answer late");
    a_write_resp_end: assert property (
        O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write response not released");
    a_cmp_min_width: assert property (
        $fell(O_COMPARE_OUT_N) |=> !O_COMPARE_OUT_N [*8])
        else $error("compare output pulse too short");
endmodule // mio_chk

bind mio_top mio_chk mio_chk_inst (
    .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N),
    .I_LOCAL_RESET_N(I_LOCAL_RESET_N), .I_PROC_SELF_RESET(I_PROC_SELF_RESET),
    .I_ARVALID(I_ARVALID), .I_BREADY(I_BREADY), .O_ARREADY(O_ARREADY),
    .O_RVALID(O_RVALID), .O_BVALID(O_BVALID),
    .O_AMP_ENABLE_OUT(O_AMP_ENABLE_OUT), .O_COMPARE_OUT_N(O_COMPARE_OUT_N),
    .O_ERROR_N(O_ERROR_N), .O_ERROR_LED(O_ERROR_LED),
    .O_CTRL_RESET(O_CTRL_RESET));

// File: verif/mio_field_model.sv
// Field side: amplifiers that move one chosen axis while enabled.
// Assumes the bench picks the moving axis, its step and one error.
`timescale 1ns/1ns
module mio_field_model (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_arst_n,
    // Bench controls
    input  wire [2:0]   i_mv_ax,
    input  wire [31:0]  i_step,
    input  wire [2:0]   i_err_ax,
    input  wire [31:0]  i_err_val,
    // Device side
    input  wire         i_amp_en,
    output reg  [255:0] o_enc_pos,
    output reg  [255:0] o_pos_err
);
    // A disabled amplifier leaves its axis standing
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_enc_pos <= 256'h0;
        end else if (i_amp_en) begin
            o_enc_pos[i_mv_ax*32+:32] <= o_enc_pos[i_mv_ax*32+:32] + i_step;
        end
    end
    always @* begin
        o_pos_err = 256'h0;
        o_pos_err[i_err_ax*32+:32] = i_err_val;
    end
endmodule // mio_field_model

// File: verif/tb.sv
// Self-checking bench for the motion I/O top with a field model.
// Assumes the checker binds itself; the random seed is fixed.
`timescale 1ns/1ns
`include "mio_defs.vh"
module tb;
    reg          clk, arst_n, lrst_n, srst;
    reg  [7:0]   ttl;
    reg  [127:0] ana;
    reg  [5:0]   awaddr, araddr;
    reg  [31:0]  wdata, step, err_val, d, e;
    reg          awvalid, wvalid, bready, arvalid, rready;
    reg  [2:0]   mv_ax, err_ax;
    wire [255:0] enc_pos, pos_err;
    wire         amp_en, cmp_n, err_n, err_led, ctrl_rst;
    wire         awready, wready, bvalid, arready, rvalid;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [15:0]  gp;
    integer      fail_count, checked, seed, i, n;
    reg  [1:0]   r;
    reg  [15:0]  gx;

    mio_top mio_top_inst (
        .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_LOCAL_RESET_N(lrst_n),
        .I_PROC_SELF_RESET(srst), .I_ENC_POS(enc_pos), .I_POS_ERR(pos_err),
        .I_TTL_IN(ttl), .I_ANALOG_IN(ana), .O_AMP_ENABLE_OUT(amp_en),
        .O_COMPARE_OUT_N(cmp_n), .O_ERROR_N(err_n), .O_ERROR_LED(err_led),
        .O_CTRL_RESET(ctrl_rst), .O_GP_OUT(gp), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
        .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
        .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
        .I_RREADY(rready));
    mio_field_model mio_field_model_inst (
        .i_clk(clk), .i_arst_n(arst_n), .i_mv_ax(mv_ax), .i_step(step),
        .i_err_ax(err_ax), .i_err_val(err_val), .i_amp_en(amp_en),
        .o_enc_pos(enc_pos), .o_pos_err(pos_err));

    task chk(input string nm, input [31:0] ex, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== ex) begin
                fail_count = fail_count + 1;
                $display("FAIL %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    task wt(input integer k);
        repeat (k) @(posedge clk);
    endtask
    // Leading edge keeps a release and a new request apart
    task axw(input [5:0] a, input [31:0] dt, output [1:0] rs);
        reg pa, pw;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= dt;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            while (pa || pw) begin
                @(posedge clk);
                if (pa && awready) begin
                    pa = 1'b0;
                    awvalid <= 1'b0;
                end
                if (pw && wready) begin
                    pw = 1'b0;
                    wvalid <= 1'b0;
                end
            end
            while (!bvalid) @(posedge clk);
            rs = bresp;
            bready <= 1'b0;
        end
    endtask
    task axr(input [5:0] a, output [31:0] dt, output [1:0] rs);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do @(posedge clk); while (!arready);
            arvalid <= 1'b0;
            do @(posedge clk); while (!rvalid);
            dt = rdata;
            rs = rresp;
            rready <= 1'b0;
        end
    endtask
    function [15:0] f_obit(input [15:0] c, input [31:0] w);
        begin
            f_obit = c;
            case (w[9:8])
                2'h1: f_obit[w[3:0]] = 1'b1;
                2'h2: f_obit[w[3:0]] = 1'b0;
                default: f_obit[w[3:0]] = w[16];
            endcase
        end
    endfunction
    function f_exc(input [31:0] v, input [31:0] lim);
        f_exc = (v[31] ? -v : v) > lim;
    endfunction
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run needs a few thousand cycles
    initial begin
        #80000;
        fail_count = fail_count + 1;
        summarize;
    end
    initial begin
        {seed, fail_count, checked, gx} = {32'd76466, 64'h0, 16'h0};
        {arst_n, lrst_n, srst, awvalid, wvalid} = 5'b01000;
        {bready, arvalid, rready, awaddr, araddr} = 15'h0;
        {ttl, ana, wdata, step, err_val} = 232'h0;
        {mv_ax, err_ax} = 6'o25;
        wt(10);
        arst_n <= 1'b1;
        wt(2);
        axr(`MIO_OFS_ERR_LIMIT, d, r);
        chk("err_limit", `MIO_RST_ERR_LIMIT, d);
        axr(`MIO_OFS_OUT_PORT, d, r);
        chk("out_port", `MIO_RST_OUT_PORT, d);
        for (i = 0; i < 24; i = i + 1) begin
            e = $random(seed);
            d = {15'h0, e[16], 6'h0, (e[9:8] == 2'h0) ? 2'h3 : e[9:8],
                 4'h0, e[3:0]};
            axw(`MIO_OFS_OUT_BIT, d, r);
            gx = f_obit(gx, d);
            wt(1);
            chk("gp_bit", gx, gp);
            if (i % 6 == 5) begin
                e = $random(seed);
                axw(`MIO_OFS_OUT_PORT, e, r);
                gx = e[15:0];
                axr(`MIO_OFS_OUT_PORT, d, r);
                chk("port_read", gx, d);
            end
        end
        axr(`MIO_OFS_OUT_BIT, d, r);
        chk("obit_read", 0, d);
        chk("obit_rresp", `MIO_RESP_OKAY, r);
        for (i = 0; i < 8; i = i + 1) begin
            e = $random(seed);
            ttl <= e[7:0];
            ana <= {$random(seed), $random(seed), $random(seed),
                    $random(seed)};
            axw(`MIO_OFS_ANALOG_IX, i, r);
            chk("aix_bresp", `MIO_RESP_OKAY, r);
            axr(`MIO_OFS_TTL_IN, d, r);
            chk("ttl_in", ttl, d);
            axr(`MIO_OFS_ANALOG_RD, d, r);
            chk("analog", ana[i*16+:12], d);
        end
        axw(6'h28, 32'h1, r);
        chk("bad_bresp", `MIO_RESP_SLVERR, r);
        axr(6'h3C, d, r);
        chk("bad_rresp", {30'h0, `MIO_RESP_SLVERR}, {d[31:2], r});
        for (i = 0; i < 3; i = i + 2) begin
            axw(`MIO_OFS_CTRL, 32'h1 << i, r);
            wt(3);
            chk("amp_off", 0, amp_en);
            axw(`MIO_OFS_CTRL, 32'h0, r);
            wt(3);
            chk("amp_on", 1, amp_en);
        end
        // Limit boundary at +0x400 and +0x401, over limit at -0x401, off-on-error on then off
        for (i = 0; i < 4; i = i + 1) begin
            e = (i == 0) ? 32'h400 : (i == 2) ? 32'hFFFF_FBFF : 32'h401;
            axw(`MIO_OFS_CTRL, (i < 3) ? 32'h2 : 32'h0, r);
            err_val <= e;
            wt(4);
            chk("err_n", !f_exc(e, 32'h400), err_n);
            chk("amp_oe", !(i < 3 && f_exc(e, 32'h400)), amp_en);
        end
        err_val <= 32'h0;
        axw(`MIO_OFS_CTRL, 32'h0, r);
        wt(4);
        chk("err_clear", 1, err_n);
        srst <= 1'b1;
        wt(3);
        chk("self_err", 2'b01, {err_n, err_led});
        srst <= 1'b0;
        wt(3);
        chk("self_clear", 1, err_n);
        axw(`MIO_OFS_OUT_PORT, 32'hA5C3, r);
        lrst_n <= 1'b0;
        wt(3);
        chk("lrst_flags", 2'b10, {ctrl_rst, err_n});
        axr(`MIO_OFS_ERR_LIMIT, d, r);
        chk("lrst_bus", 32'h400, d);
        lrst_n <= 1'b1;
        wt(3);
        chk("lrst_gp", 2'b0, {gp, ctrl_rst});
        step <= 32'h1;
        axw(`MIO_OFS_CMP_VALUE, 32'h190, r);
        axw(`MIO_OFS_CMP_CFG, 32'h26, r);
        n = 0;
        repeat (500) begin
            @(posedge clk);
            n = n + !cmp_n;
        end
        chk("cmp_other_axis", 0, n);
        axw(`MIO_OFS_CMP_CFG, 32'h22, r);
        n = 0;
        while (cmp_n && n < 600) begin
            @(posedge clk);
            n = n + 1;
        end
        chk("cmp_fire", 0, cmp_n);
        n = 0;
        while (!cmp_n && n < 400) begin
            @(posedge clk);
            n = n + 1;
        end
        chk("cmp_width", `MIO_CMP_PULSE_NS / `MIO_CLK_PERIOD_NS, n);
        axw(`MIO_OFS_CMP_VALUE, enc_pos[95:64] + 32'd60, r);
        axw(`MIO_OFS_CMP_CFG, 32'h32, r);
        wt(150);
        chk("setpoint_fire", 0, cmp_n);
        wt(300);
        chk("setpoint_hold", 0, cmp_n);
        summarize;
    end
endmodule // tb
